//--- bench/status_reader.sv
// Application controller model that reads the interrupt status bytes
`timescale 1ns/1ps
module status_reader (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    output logic rd_latch_o,
    output logic rd_sel_o,
    output logic rd_last_bit_o
);
    initial begin
        rd_latch_o = 1'b0;
        rd_sel_o = 1'b0;
        rd_last_bit_o = 1'b0;
    end
    // Latch, shift for gap cycles (at least one), then the clearing bit
    task automatic read(input logic sel, input int gap,
                        output logic [7:0] data);
        @(posedge clk_i);
        rd_sel_o <= sel;
        rd_latch_o <= 1'b1;
        @(posedge clk_i);
        rd_latch_o <= 1'b0;
        @(posedge clk_i);
        #1 data = rd_data_i;
        repeat (gap) @(posedge clk_i);
        rd_last_bit_o <= 1'b1;
        @(posedge clk_i);
        rd_last_bit_o <= 1'b0;
        // Idle select points at the other byte, never at a stale choice
        rd_sel_o <= ~sel;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    // Each read clears its byte, so both are taken after an interrupt
    task automatic read_both(output logic [7:0] lo, output logic [7:0] hi);
        read(1'b0, 2, lo);
        read(1'b1, 2, hi);
    endtask
endmodule // status_reader

//--- bench/tb.sv
// Self-checking bench for the interrupt and pin routing block
`timescale 1ns/1ps
module tb;
    import irq_route_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b = 1'b0, p_on = 1'b1, rph = 1'b0, por_ind = 1'b0;
    logic rx_active = 1'b1;
    cfg_events_t ev = '0;
    rx_mode_t [3:0] mode = {4{MODE_PACKET_TRANSPARENT}};
    logic [3:0] ext = 4'h0;
    logic [7:0] mask_lo = 8'hFF, mask_hi = 8'hFF;
    logic [7:0] run_lo = RUN_CFG_RESET, run_hi = RUN_CFG_RESET;
    logic [4:0] pol = 5'h10;
    pin_src_t [3:0] sel = {SRC_LOW, SRC_HIGH, SRC_RX_RUN, SRC_IRQ};
    logic [1:0] act = 2'h0;
    rx_sigs_t sigs = '0;
    logic rd_latch, rd_sel, rd_last, por_flag;
    logic [7:0] rd_data, flag_lo, flag_hi, d, e;
    logic [3:0] pins, oe;
    int bad_count = 0, compares = 0;
    always #25 clk_i = ~clk_i;
    irq_pin_router DUT (.clk_i(clk_i), .rst_b_i(rst_b), .p_on_i(p_on),
        .reset_phase_i(rph), .events_i(ev), .por_ind_i(por_ind),
        .rx_mode_i(mode), .ext_proc_i(ext), .irq_mask_reg_low_i(mask_lo),
        .irq_mask_reg_high_i(mask_hi), .pin_polarity_config_i(pol),
        .pin_sel_i(sel), .running_flag_cfg_low_i(run_lo),
        .running_flag_cfg_high_i(run_hi), .rx_active_i(rx_active),
        .active_cfg_i(act), .sigs_i(sigs), .rd_latch_i(rd_latch),
        .rd_sel_i(rd_sel), .rd_last_bit_i(rd_last), .rd_data_o(rd_data),
        .irq_flag_reg_low_o(flag_lo), .irq_flag_reg_high_o(flag_hi),
        .por_flag_o(por_flag), .out_pin_any_o(pins), .out_pin_oe_o(oe));
    status_reader ctl (.clk_i(clk_i), .rd_data_i(rd_data),
        .rd_latch_o(rd_latch), .rd_sel_o(rd_sel), .rd_last_bit_o(rd_last));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(input cfg_events_t x, input logic p);
        @(posedge clk_i);
        ev <= x;
        por_ind <= p;
        @(posedge clk_i);
        ev <= '0;
        por_ind <= 1'b0;
        settle();
    endtask
    task automatic t_reset;
        repeat (20) @(posedge clk_i);
        check({flag_hi, flag_lo}, 16'hFFFF);
        check({por_flag, pins, oe}, 9'h100);
        rst_b <= 1'b1;
        settle();
        check(oe, 4'hF);
        check(pins, 4'h6);
        check({flag_hi, flag_lo}, 16'hFFFF);
    endtask
    task automatic t_first;
        pulse(16'h0001, 1'b0);
        check({flag_hi, flag_lo}, 16'h0001);
        check(pins[0], 1'b1);
        ctl.read(1'b0, 3, d);
        check(d, 8'h01);
        check(flag_lo, 8'h00);
        check(pins[0], 1'b0);
    endtask
    task automatic t_mask;
        mask_lo <= 8'hFE;
        pulse(16'h0002, 1'b0);
        check({flag_lo, pins[0]}, 9'h004);
        pulse(16'h0001, 1'b0);
        check({flag_lo, pins[0]}, 9'h003);
        pol <= 5'h00;
        settle();
        check(pins[0], 1'b0);
        rph <= 1'b1;
        settle();
        check(pins[0], 1'b1);
        rph <= 1'b0;
        ctl.read(1'b0, 1, d);
        check(pins[0], 1'b1);
        pol <= 5'h10;
        mask_lo <= 8'hFF;
    endtask
    task automatic t_cross;
        pulse(16'h0001, 1'b0);
        pulse(16'h00F0, 1'b0);
        pulse(16'h0F00, 1'b0);
        pulse(16'hF000, 1'b0);
        check({flag_hi, flag_lo}, 16'hFCFD);
        pulse(16'h0010, 1'b0);
        check({flag_hi, flag_lo}, 16'h0C05);
        pulse(16'h0002, 1'b0);
        check({flag_hi, flag_lo}, 16'h0002);
        ctl.read_both(d, e);
        check({e, d}, 16'h0002);
    endtask
    task automatic t_modes;
        rx_mode_t mm [5] = '{MODE_CHIP_DATA_STROBE, MODE_MATCHED_FILTER,
            MODE_RAW_SLICER, MODE_PACKET_FIFO, MODE_PACKET_FIFO};
        logic [7:0] xp [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'hFD};
        for (int i = 0; i < 5; i++) begin
            mode <= {4{mm[i]}};
            ext <= (i == 3) ? 4'hF : 4'h0;
            pulse(16'hFFF5, 1'b0);
            ctl.read_both(d, e);
            check({e, d}, {xp[i], xp[i]});
        end
        mode <= {4{MODE_PACKET_TRANSPARENT}};
        ext <= 4'h0;
    endtask
    task automatic t_loss;
        mask_hi <= 8'hFE;
        pulse(16'h0008, 1'b0);
        fork
            ctl.read(1'b1, 6, d);
            begin
                pulse(16'h0004, 1'b0);
                check(flag_hi, 8'h01);
                check(pins[0], 1'b1);
            end
        join
        check(d, 8'h02);
        check({flag_hi, pins[0]}, 9'h000);
        mask_hi <= 8'hFF;
    endtask
    task automatic t_por;
        pulse(16'h0000, 1'b1);
        check({por_flag, pins[0]}, 2'h3);
        ctl.read(1'b1, 1, d);
        check({por_flag, pins[0]}, 2'h0);
    endtask
    function automatic logic exp_pin(int p, int c);
        logic [7:0] rc;
        logic v;
        rc = (p < 2) ? run_lo : run_hi;
        case (c)
            0: v = (p == 3) ? 1'b0 : sigs.clk_out;
            1: v = rx_active & rc[4 * (p % 2) + act];
            4: v = 1'b1;
            5: v = sigs.sliced_data;
            6: v = sigs.matched_filter_data;
            7: v = sigs.encoded_chip_data;
            8: v = sigs.chip_strobe;
            9: v = sigs.rx_data;
            10: v = sigs.received_payload_strobe;
            default: v = 1'b0;
        endcase
        return v ^ pol[p];
    endfunction
    task automatic t_pins;
        run_lo <= 8'h5A;
        run_hi <= 8'hC3;
        act <= 2'h1;
        // Code 11 lies outside the source list and must give a low level before the pin inversion
        for (int c = 0; c < 12; c++) begin
            for (int k = 0; k < 4; k++) begin
                sel <= {4{pin_src_t'(c)}};
                pol <= {1'b1, k[0] ? 4'h5 : 4'hA};
                sigs <= k[1] ? 7'h2D : 7'h52;
                settle();
                for (int p = 0; p < 4; p++) begin
                    check(pins[p], exp_pin(p, c));
                end
            end
        end
        sel <= {4{SRC_RX_RUN}};
        pol <= 5'h10;
        act <= 2'h2;
        settle();
        check(pins, 4'hA);
        p_on <= 1'b0;
        settle();
        check({pins, oe}, 8'h00);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        conclude();
    end
    initial begin
        t_reset();
        t_first();
        t_mask();
        t_cross();
        t_modes();
        t_loss();
        t_por();
        t_pins();
        conclude();
    end
endmodule // tb

//--- common/irq_route_pkg.sv
// Shared types and constants for the interrupt and output pin routing block
package irq_route_pkg;

    localparam int NUM_CFG = 4;
    localparam int NUM_PINS = 4;

    // Flag byte layout for one configuration pair (low reg A/B, high reg C/D)
    localparam int FLAG_WU_POS = 0;
    localparam int FLAG_FS_POS = 2;
    localparam int FLAG_MID_POS = 4;
    localparam int FLAG_EOM_POS = 6;
    localparam logic [3:0] PAIR_LOW_BITS = 4'h3;
    localparam logic [3:0] PAIR_HIGH_BITS = 4'hC;

    // Bits of the pin polarity configuration
    localparam int IRQ_POL_POS = 4;

    // Reset values
    localparam logic [7:0] RUN_CFG_RESET = 8'hFF;
    localparam logic [7:0] MASK_NONE = 8'h00;

    typedef enum logic [2:0] {
        MODE_PACKET_TRANSPARENT,
        MODE_PACKET_FIFO,
        MODE_CHIP_DATA_STROBE,
        MODE_MATCHED_FILTER,
        MODE_RAW_SLICER
    } rx_mode_t;

    typedef enum logic [3:0] {
        SRC_CLK_OUT,
        SRC_RX_RUN,
        SRC_IRQ,
        SRC_LOW,
        SRC_HIGH,
        SRC_SLICED_DATA,
        SRC_MATCHED_FILTER,
        SRC_CHIP_DATA,
        SRC_CHIP_STROBE,
        SRC_RX_DATA,
        SRC_RX_STROBE
    } pin_src_t;

    // One bit per configuration A..D in each field
    typedef struct packed {
        logic [3:0] end_of_message;
        logic [3:0] message_id;
        logic [3:0] frame_sync;
        logic [3:0] wakeup;
    } cfg_events_t;

    typedef struct packed {
        logic clk_out;
        logic sliced_data;
        logic matched_filter_data;
        logic encoded_chip_data;
        logic chip_strobe;
        logic rx_data;
        logic received_payload_strobe;
    } rx_sigs_t;

    typedef struct packed {
        cfg_events_t flags;
        logic por_flag;
        logic fresh;
        logic forced;
        logic irq;
        logic [7:0] snap;
        logic rd_sel;
        logic rd_open;
        logic [3:0] pin;
        logic [3:0] pin_oe;
    } core_state_t;

endpackage

//--- verilog/event_qualifier.sv
// Receive-mode gating of the raw interrupt events
`timescale 1ns/1ps
module event_qualifier import irq_route_pkg::*; (
    input cfg_events_t events_i,
    input rx_mode_t [3:0] rx_mode_i,
    input wire logic [3:0] ext_proc_i,
    output cfg_events_t events_o
);

    logic [3:0] packet_ok;

    always_comb begin
        for (int c = 0; c < NUM_CFG; c++) begin
            packet_ok[c] = (rx_mode_i[c] == MODE_PACKET_TRANSPARENT ||
                            rx_mode_i[c] == MODE_PACKET_FIFO) &&
                           !ext_proc_i[c];
        end
        events_o.wakeup = events_i.wakeup;
        events_o.frame_sync = events_i.frame_sync & packet_ok;
        events_o.message_id = events_i.message_id & packet_ok;
        events_o.end_of_message = events_i.end_of_message & packet_ok;
    end

endmodule // event_qualifier

//--- verilog/irq_pin_router.sv
// Interrupt flags, interrupt line and output pin routing of the receiver
//
// Functional notes
// - Unmasked pending events drive the interrupt line
// - Firing source sets its own status bit
// - Interrupt polarity selectable, fixed during reset phase
// - Reset sets all flags, interrupt low
// - First event after reset clears flags, asserts
// - Wake-up clears frame-syncs and partner wake-up
// - Frame-sync clears message-ID, end-of-message, partner sync
// - Reading a status register clears it
// - Power-on indicator ignores the mask registers
// - Wake-up events pass in every mode
// - Packet events only in packet modes
// - Status byte latched after last address bit
// - Status cleared after last data bit out
// - Events of the register being read inside its read window are lost
// - Unmasked events still reach the interrupt line
// - Power-on low puts outputs high impedance
// - Each pin selects one of eleven sources
// - Fourth pin cannot carry the clock output
// - Per-pin output inversion
// - Running indication enabled for all configurations at reset (enables all ones)
// - Per-pin, per-configuration running indication enables
// - External processing suppresses packet events
`timescale 1ns/1ps
module irq_pin_router import irq_route_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic p_on_i,
    input wire logic reset_phase_i,
    input cfg_events_t events_i,
    input wire logic por_ind_i,
    input rx_mode_t [3:0] rx_mode_i,
    input wire logic [3:0] ext_proc_i,
    input wire logic [7:0] irq_mask_reg_low_i,
    input wire logic [7:0] irq_mask_reg_high_i,
    input wire logic [4:0] pin_polarity_config_i,
    input pin_src_t [3:0] pin_sel_i,
    input wire logic [7:0] running_flag_cfg_low_i,
    input wire logic [7:0] running_flag_cfg_high_i,
    input wire logic rx_active_i,
    input wire logic [1:0] active_cfg_i,
    input rx_sigs_t sigs_i,
    input wire logic rd_latch_i,
    input wire logic rd_sel_i,
    input wire logic rd_last_bit_i,
    output logic [7:0] rd_data_o,
    output logic [7:0] irq_flag_reg_low_o,
    output logic [7:0] irq_flag_reg_high_o,
    output logic por_flag_o,
    output logic [3:0] out_pin_any_o,
    output logic [3:0] out_pin_oe_o
);

    // Packs the flags of one configuration pair into a status byte
    function automatic logic [7:0] get_pair(input cfg_events_t f,
                                            input logic k);
        int i;
        i = k ? 2 : 0;
        return {f.end_of_message[i+1], f.end_of_message[i],
                f.message_id[i+1], f.message_id[i],
                f.frame_sync[i+1], f.frame_sync[i],
                f.wakeup[i+1], f.wakeup[i]};
    endfunction

    // All flag positions that belong to one status register
    function automatic cfg_events_t pair_mask(input logic k);
        logic [3:0] b;
        b = k ? PAIR_HIGH_BITS : PAIR_LOW_BITS;
        return '{end_of_message: b, message_id: b,
                 frame_sync: b, wakeup: b};
    endfunction

    localparam core_state_t CORE_RESET = '{
        flags: '1,
        por_flag: 1'b1,
        fresh: 1'b1,
        forced: 1'b0,
        irq: 1'b0,
        snap: 8'h00,
        rd_sel: 1'b0,
        rd_open: 1'b0,
        pin: 4'h0,
        pin_oe: 4'h0
    };

    core_state_t state_reg;
    core_state_t state_next;
    cfg_events_t q_events;
    cfg_events_t clr;
    logic any_event;
    logic irq_line;
    logic [15:0] run_cfg;
    logic [3:0] run_bit;
    logic [3:0] mux_level;
    logic [7:0] pend_low;
    logic [7:0] pend_high;

    event_qualifier u_qual (
        .events_i(events_i),
        .rx_mode_i(rx_mode_i),
        .ext_proc_i(ext_proc_i),
        .events_o(q_events)
    );

    assign any_event = (|q_events) | por_ind_i;

    // The reset-phase level is state_reg.irq uninverted, so the polarity
    // bit has no effect while the supply is still settling.
    assign irq_line = reset_phase_i ? state_reg.irq :
        (pin_polarity_config_i[IRQ_POL_POS] ? state_reg.irq
                                            : !state_reg.irq);

    // Bits 4*pin+cfg; both registers reset to all ones
    assign run_cfg = {running_flag_cfg_high_i, running_flag_cfg_low_i};

    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : g_pin
            assign run_bit[p] = rx_active_i &
                run_cfg[4*p + int'(active_cfg_i)];

            out_pin_mux #(
                .CLK_ALLOWED(p != NUM_PINS - 1)
            ) u_mux (
                .sel_i(pin_sel_i[p]),
                .invert_i(pin_polarity_config_i[p]),
                .sigs_i(sigs_i),
                .run_i(run_bit[p]),
                .irq_i(irq_line),
                .level_o(mux_level[p])
            );
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        for (int c = 0; c < NUM_CFG; c++) begin
            clr.wakeup[c] = q_events.wakeup[c ^ 1];
            clr.frame_sync[c] = (|q_events.wakeup) |
                                q_events.frame_sync[c ^ 1];
            clr.message_id[c] = |q_events.frame_sync;
            clr.end_of_message[c] = |q_events.frame_sync;
        end

        if (state_reg.fresh) begin
            // Flags read all ones until the first event wipes them
            if (any_event) begin
                state_next.flags = q_events;
                state_next.por_flag = por_ind_i;
                state_next.fresh = 1'b0;
                state_next.forced = 1'b1;
            end
        end else begin
            // A set in the same cycle as a cross-clear wins
            state_next.flags = cfg_events_t'(
                (state_reg.flags & ~clr) | q_events);
            state_next.por_flag = state_reg.por_flag | por_ind_i;
        end

        if (rd_latch_i) begin
            state_next.snap = get_pair(state_reg.flags, rd_sel_i);
            state_next.rd_sel = rd_sel_i;
            state_next.rd_open = 1'b1;
        end

        // The clear beats events of the same cycle, so anything raised in the read register
        // since the latch is gone; the line pulsed only for those raised before the clear cycle.
        if (rd_last_bit_i && state_reg.rd_open) begin
            state_next.flags = cfg_events_t'(state_next.flags &
                ~pair_mask(state_reg.rd_sel));
            if (state_reg.rd_sel) begin
                state_next.por_flag = 1'b0;
            end
            state_next.forced = 1'b0;
            state_next.rd_open = 1'b0;
        end

        pend_low = get_pair(state_next.flags, 1'b0) & ~irq_mask_reg_low_i;
        pend_high = get_pair(state_next.flags, 1'b1) & ~irq_mask_reg_high_i;
        state_next.irq = !state_next.fresh &
            (state_next.forced | (|pend_low) |
             (|pend_high) | state_next.por_flag);

        state_next.pin = p_on_i ? mux_level : 4'h0;
        state_next.pin_oe = {NUM_PINS{p_on_i}};
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= CORE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data_o = state_reg.snap;
    assign irq_flag_reg_low_o = get_pair(state_reg.flags, 1'b0);
    assign irq_flag_reg_high_o = get_pair(state_reg.flags, 1'b1);
    assign por_flag_o = state_reg.por_flag;
    assign out_pin_any_o = state_reg.pin;
    assign out_pin_oe_o = state_reg.pin_oe;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_read_latch;
        rd_latch_i && !rd_last_bit_i;
    endsequence

    sequence s_read_clear;
        rd_last_bit_i && state_reg.rd_open && !rd_latch_i;
    endsequence

    property p_reset_quiet;
        state_reg.fresh |-> !state_reg.irq &&
            state_reg.flags == cfg_events_t'('1);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("flags or line wrong before first event");

    property p_first_event;
        state_reg.fresh && any_event |=> state_reg.irq && !state_reg.fresh;
    endproperty
    a_first_event: assert property (p_first_event)
        else $error("first event did not raise the line");

    property p_wakeup_clears;
        !state_reg.fresh && (|q_events.wakeup) && !rd_last_bit_i &&
            q_events.frame_sync == 4'h0
            |=> state_reg.flags.frame_sync == 4'h0;
    endproperty
    a_wakeup_clears: assert property (p_wakeup_clears)
        else $error("wake-up left a frame-sync flag set");

    property p_sync_clears;
        !state_reg.fresh && (|q_events.frame_sync) && !rd_last_bit_i &&
            q_events.message_id == 4'h0 && q_events.end_of_message == 4'h0
            |=> state_reg.flags.message_id == 4'h0 &&
                state_reg.flags.end_of_message == 4'h0;
    endproperty
    a_sync_clears: assert property (p_sync_clears)
        else $error("frame-sync left a message flag set");

    // The controller shifts several bits between the two read points
    property p_latch_then_clear;
        s_read_latch ##[1:10] s_read_clear |=>
            get_pair(state_reg.flags, state_reg.rd_sel) == 8'h00 &&
            rd_data_o == $past(state_reg.snap);
    endproperty
    a_latch_then_clear: assert property (p_latch_then_clear)
        else $error("status not cleared at end of read");

    property p_snapshot;
        s_read_latch |=> rd_data_o == get_pair($past(state_reg.flags),
                                               $past(rd_sel_i));
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("snapshot does not match status");

    property p_por_unmaskable;
        state_reg.por_flag && !state_reg.fresh |-> state_reg.irq;
    endproperty
    a_por_unmaskable: assert property (p_por_unmaskable)
        else $error("power-on flag did not raise the line");

    property p_unmasked_wakeup;
        !state_reg.fresh && state_reg.flags.wakeup[0] &&
            !$past(irq_mask_reg_low_i[FLAG_WU_POS]) |-> state_reg.irq;
    endproperty
    a_unmasked_wakeup: assert property (p_unmasked_wakeup)
        else $error("unmasked flag without interrupt");

    property p_sticky;
        !state_reg.fresh && state_reg.flags.wakeup[0] && !rd_last_bit_i &&
            !q_events.wakeup[1] |=> state_reg.flags.wakeup[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a clear");

    property p_high_z;
        !p_on_i |=> out_pin_oe_o == 4'h0 && out_pin_any_o == 4'h0;
    endproperty
    a_high_z: assert property (p_high_z)
        else $error("pins driven while power-on low");

endmodule // irq_pin_router

//--- verilog/out_pin_mux.sv
// Source selection and inversion for one digital output pin
`timescale 1ns/1ps
module out_pin_mux import irq_route_pkg::*; #(
    parameter bit CLK_ALLOWED = 1'b1
) (
    input pin_src_t sel_i,
    input wire logic invert_i,
    input rx_sigs_t sigs_i,
    input wire logic run_i,
    input wire logic irq_i,
    output logic level_o
);

    logic raw;

    always_comb begin
        raw = 1'b0;
        unique case (sel_i)
            SRC_CLK_OUT: raw = CLK_ALLOWED ? sigs_i.clk_out : 1'b0;
            SRC_RX_RUN: raw = run_i;
            SRC_IRQ: raw = irq_i;
            SRC_LOW: raw = 1'b0;
            SRC_HIGH: raw = 1'b1;
            SRC_SLICED_DATA: raw = sigs_i.sliced_data;
            SRC_MATCHED_FILTER: raw = sigs_i.matched_filter_data;
            SRC_CHIP_DATA: raw = sigs_i.encoded_chip_data;
            SRC_CHIP_STROBE: raw = sigs_i.chip_strobe;
            SRC_RX_DATA: raw = sigs_i.rx_data;
            SRC_RX_STROBE: raw = sigs_i.received_payload_strobe;
            // Unused select codes give a low level before the pin inversion
            default: raw = 1'b0;
        endcase
        level_o = raw ^ invert_i;
    end

endmodule // out_pin_mux
